// >>> lpps_pkg.sv
// lpps_pkg: modes, pin functions and pad actions for the low power pin state control
// assumes the power controller encodes its mode as lpps_mode_type
package lpps_pkg;

    // power / reset mode indication
    typedef enum logic [3:0] {
        LPPS_MODE_POR       = 4'h0,
        LPPS_MODE_EXT_RST   = 4'h1,
        LPPS_MODE_INT_RST   = 4'h2,
        LPPS_MODE_RUN       = 4'h3,
        LPPS_MODE_SLEEP     = 4'h4,
        LPPS_MODE_TIMER     = 4'h5,
        LPPS_MODE_SUB_TIMER = 4'h6,
        LPPS_MODE_SUBCR_TMR = 4'h7,
        LPPS_MODE_RTC       = 4'h8,
        LPPS_MODE_STOP      = 4'h9,
        LPPS_MODE_DS_RTC    = 4'ha,
        LPPS_MODE_DS_STOP   = 4'hb,
        LPPS_MODE_DS_RETURN = 4'hc
    } lpps_mode_type;

    // pin function selection
    typedef enum logic [2:0] {
        LPPS_FUNC_GPIO     = 3'h0,
        LPPS_FUNC_WAKEUP   = 3'h1,
        LPPS_FUNC_USB      = 3'h2,
        LPPS_FUNC_EXC2     = 3'h3,
        LPPS_FUNC_EXC3     = 3'h4,
        LPPS_FUNC_RESOURCE = 3'h5
    } lpps_func_type;

    // output enable is low while the pad drives
    localparam logic LPPS_OE_DRIVE = 1'h0;
    localparam logic LPPS_OE_HIZ = 1'h1;
    localparam logic LPPS_FIXED_LEVEL = 1'h0;

endpackage

// >>> lpps_pin_ctrl.sv
// lpps_pin_ctrl: per-pin pad state selection from power mode, function and hold select
// assumes mode, function and control inputs come from logic on clk_i
// assumes pad cells float the pad while its oe_n is high
`timescale 1ns/10ps

// pad controls per pin:
// oe_n: high floats the pad, low lets it drive
// in_en: enables the input buffer
// hold: keeps the state from before the mode change
// gpio: hands the pad back to the port logic
// fixed: ties the internal input to 0
// main_run and sub_run enable the oscillators; sub_hold keeps the sub pad

module lpps_pin_ctrl
    import lpps_pkg::*;
#(
    // number of pads handled
    parameter int PINS = 4
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // mode indications
    input wire lpps_mode_type mode_i,
    input wire logic pin_hold_select_i,
    input wire logic sub_osc_stop_ctrl_i,
    input wire logic backup_por_i,
    input wire logic usb_transmit_i,
    // pin function selection
    input wire lpps_func_type pin_func_i [PINS],
    // pad controls per pin
    output logic [PINS-1:0] pad_oe_n_o,
    output logic [PINS-1:0] pad_in_en_o,
    output logic [PINS-1:0] pad_hold_o,
    output logic [PINS-1:0] pad_force_gpio_o,
    output logic [PINS-1:0] input_fixed_o,
    // oscillator pads
    output logic main_osc_run_o,
    output logic main_osc_oe_n_o,
    output logic sub_osc_run_o,
    output logic sub_osc_hold_o,
    output logic sub_osc_oe_n_o
);

    // pad controls of every pin and both oscillator pads, kept in one register
    typedef struct packed {
        logic [PINS-1:0] oe_n;
        logic [PINS-1:0] in_en;
        logic [PINS-1:0] hold;
        logic [PINS-1:0] gpio;
        logic [PINS-1:0] fixed;
        logic main_run;
        logic main_oe_n;
        logic sub_run;
        logic sub_hold;
        logic sub_oe_n;
    } lpps_state_type;

    // registered pad state and the value it takes at the next edge
    lpps_state_type state;
    lpps_state_type next_state;

    // mode groups shared by the pin and oscillator decode
    logic deep;
    logic low_stop;
    logic rtc_stop;
    logic stop_any;
    logic in_reset;
    logic run_sleep;

    // mode classification
    always_comb begin
        // deep standby rtc or deep standby stop
        deep = (mode_i == LPPS_MODE_DS_RTC) || (mode_i == LPPS_MODE_DS_STOP);
        // rtc or stop, where the exception pins change over
        rtc_stop = (mode_i == LPPS_MODE_RTC) || (mode_i == LPPS_MODE_STOP);
        // modes in which the sub oscillator may be halted
        stop_any = (mode_i == LPPS_MODE_STOP) || (mode_i == LPPS_MODE_DS_STOP);
        // every mode in which the main oscillator is stopped
        low_stop = rtc_stop || deep
            || (mode_i == LPPS_MODE_SUB_TIMER) || (mode_i == LPPS_MODE_SUBCR_TMR);
        // reset states: pads released, nothing kept
        in_reset = (mode_i == LPPS_MODE_POR) || (mode_i == LPPS_MODE_EXT_RST)
            || (mode_i == LPPS_MODE_INT_RST);
        // only run and sleep let the pads follow their function freely
        run_sleep = (mode_i == LPPS_MODE_RUN) || (mode_i == LPPS_MODE_SLEEP);
    end

    // next pad state; default is drive enabled, previous state kept outside run and sleep
    always_comb begin
        next_state = state;
        // every pin decodes on its own; pin i follows function i
        for (int i = 0; i < PINS; i++) begin
            // defaults: drive, input on, keep state outside run and sleep
            next_state.oe_n[i] = LPPS_OE_DRIVE;
            next_state.in_en[i] = 1'h1;
            next_state.hold[i] = !run_sleep;
            next_state.gpio[i] = 1'h0;
            next_state.fixed[i] = 1'h0;
            // backup power-on wins over everything for resource pins
            if (backup_por_i && pin_func_i[i] == LPPS_FUNC_RESOURCE) begin
                next_state.oe_n[i] = LPPS_OE_HIZ;
                next_state.hold[i] = 1'h0;
            end else if (in_reset) begin
                // reset states release the pad and keep nothing
                next_state.oe_n[i] = LPPS_OE_HIZ;
                next_state.hold[i] = 1'h0;
            end else begin
                // function decode for the low power modes
                unique case (pin_func_i[i])
                    // usb pads never drive here; receive ties the internal input
                    LPPS_FUNC_USB: begin
                        next_state.hold[i] = 1'h0;
                        if (usb_transmit_i) begin
                            // transmit: the transceiver owns the pad
                            next_state.oe_n[i] = LPPS_OE_HIZ;
                        end else begin
                            // receive: input buffer stays on, internal input tied
                            next_state.oe_n[i] = LPPS_OE_HIZ;
                            next_state.fixed[i] = 1'h1;
                        end
                    end
                    // hold select in deep standby: float, keep the wakeup path
                    LPPS_FUNC_WAKEUP: begin
                        if (deep && pin_hold_select_i) begin
                            next_state.oe_n[i] = LPPS_OE_HIZ;
                            next_state.hold[i] = 1'h0;
                        end
                    end
                    // second exception: timer keeps, rtc and stop fall back to gpio
                    LPPS_FUNC_EXC2: begin
                        if (rtc_stop) begin
                            next_state.gpio[i] = 1'h1;
                            next_state.fixed[i] = 1'h1;
                            next_state.hold[i] = 1'h0;
                        end
                    end
                    // third exception: timer keeps, rtc and stop float the pad
                    LPPS_FUNC_EXC3: begin
                        if (rtc_stop) begin
                            next_state.oe_n[i] = LPPS_OE_HIZ;
                            next_state.fixed[i] = 1'h1;
                            next_state.hold[i] = 1'h0;
                        end
                    end
                    // plain pins float in deep standby
                    LPPS_FUNC_GPIO, LPPS_FUNC_RESOURCE: begin
                        if (deep) begin
                            next_state.oe_n[i] = LPPS_OE_HIZ;
                            next_state.fixed[i] = 1'h1;
                            next_state.hold[i] = 1'h0;
                        end
                    end
                    // undefined codes float with the input tied, the safe choice
                    default: begin
                        next_state.oe_n[i] = LPPS_OE_HIZ;
                        next_state.fixed[i] = 1'h1;
                    end
                endcase
            end
            // a tied input turns the buffer off, except usb, which still receives
            if (next_state.fixed[i]) begin
                next_state.in_en[i] = (pin_func_i[i] == LPPS_FUNC_USB);
            end
        end
        // main oscillator: run and pad from one decode so they never disagree
        next_state.main_run = !low_stop;
        next_state.main_oe_n = low_stop ? LPPS_OE_HIZ : LPPS_OE_DRIVE;
        // sub oscillator: the stop control only acts in stop and deep standby stop
        if (sub_osc_stop_ctrl_i && stop_any) begin
            next_state.sub_run = 1'h0;
            next_state.sub_hold = 1'h0;
            next_state.sub_oe_n = LPPS_OE_HIZ;
        end else begin
            next_state.sub_run = 1'h1;
            next_state.sub_hold = 1'h1;
            next_state.sub_oe_n = LPPS_OE_DRIVE;
        end
    end

    // register the pad state to keep mode changes glitch free
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            // reset floats every pin and leaves both oscillators running
            state <= '{
                oe_n: '1,
                in_en: '0,
                hold: '0,
                gpio: '0,
                fixed: '0,
                main_run: 1'h1,
                main_oe_n: 1'h0,
                sub_run: 1'h1,
                sub_hold: 1'h1,
                sub_oe_n: 1'h0
            };
        end else begin
            state <= next_state;
        end
    end

    // pin pads straight from the state register
    assign pad_oe_n_o = state.oe_n;
    assign pad_in_en_o = state.in_en;
    assign pad_hold_o = state.hold;
    assign pad_force_gpio_o = state.gpio;
    assign input_fixed_o = state.fixed;
    // oscillator pads straight from the state register
    assign main_osc_run_o = state.main_run;
    assign main_osc_oe_n_o = state.main_oe_n;
    assign sub_osc_run_o = state.sub_run;
    assign sub_osc_hold_o = state.sub_hold;
    assign sub_osc_oe_n_o = state.sub_oe_n;

endmodule

// >>> lpps_pin_ctrl_chk.sv
// lpps_pin_ctrl_chk: pad state checks on pin 0 and the oscillator pads
// assumes binding to lpps_pin_ctrl, outputs follow inputs one edge later
`timescale 1ns/10ps
module lpps_pin_ctrl_chk
    import lpps_pkg::*;
#(
    parameter int PINS = 4
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // mode and function
    input wire lpps_mode_type mode_i,
    input wire logic pin_hold_select_i,
    input wire logic sub_osc_stop_ctrl_i,
    input wire logic backup_por_i,
    input wire logic usb_transmit_i,
    input wire lpps_func_type pin_func_i [PINS],
    // pad controls
    input wire logic [PINS-1:0] pad_oe_n_o,
    input wire logic [PINS-1:0] pad_in_en_o,
    input wire logic [PINS-1:0] pad_hold_o,
    input wire logic [PINS-1:0] pad_force_gpio_o,
    input wire logic [PINS-1:0] input_fixed_o,
    input wire logic main_osc_run_o,
    input wire logic main_osc_oe_n_o,
    input wire logic sub_osc_run_o,
    input wire logic sub_osc_hold_o,
    input wire logic sub_osc_oe_n_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    // mode groups and pin 0 function
    logic deep, lowm;
    lpps_func_type f;
    assign deep = mode_i inside {LPPS_MODE_DS_RTC, LPPS_MODE_DS_STOP};
    assign lowm = mode_i inside {LPPS_MODE_RTC, LPPS_MODE_STOP};
    assign f = pin_func_i[0];
    // pad state checks
    AST_WAKE_HIZ: assert property (deep && pin_hold_select_i && f == LPPS_FUNC_WAKEUP
        |=> pad_oe_n_o[0] && pad_in_en_o[0] && !pad_hold_o[0])
        else $error("wakeup pin not released with input on");
    AST_USB_RX: assert property (f == LPPS_FUNC_USB && !usb_transmit_i
        && mode_i inside {[LPPS_MODE_RUN:LPPS_MODE_DS_STOP]}
        |=> pad_oe_n_o[0] && pad_in_en_o[0] && input_fixed_o[0])
        else $error("usb receive state wrong");
    AST_MAIN_STOP: assert property (mode_i inside {[LPPS_MODE_SUB_TIMER:LPPS_MODE_DS_STOP]}
        |=> !main_osc_run_o && main_osc_oe_n_o)
        else $error("main oscillator pad not stopped");
    AST_EXC2: assert property (lowm && f == LPPS_FUNC_EXC2
        |=> pad_force_gpio_o[0] && input_fixed_o[0] && !pad_oe_n_o[0] && !pad_in_en_o[0])
        else $error("second exception pin not gpio");
    AST_EXC_TIMER: assert property (mode_i == LPPS_MODE_TIMER
        && f inside {LPPS_FUNC_EXC2, LPPS_FUNC_EXC3} |=> pad_hold_o[0])
        else $error("exception pin not kept in timer");
    AST_EXC3: assert property (lowm && f == LPPS_FUNC_EXC3
        |=> pad_oe_n_o[0] && input_fixed_o[0] && !pad_force_gpio_o[0])
        else $error("third exception pin not released");
    AST_SUB_KEEP: assert property (!sub_osc_stop_ctrl_i
        |=> sub_osc_hold_o && sub_osc_run_o && !sub_osc_oe_n_o)
        else $error("sub oscillator pad not kept");
    AST_SUB_STOP: assert property (sub_osc_stop_ctrl_i
        && mode_i inside {LPPS_MODE_STOP, LPPS_MODE_DS_STOP} |=> !sub_osc_run_o && sub_osc_oe_n_o)
        else $error("sub oscillator pad not stopped");
    AST_BKP_HIZ: assert property (backup_por_i && f == LPPS_FUNC_RESOURCE |=> pad_oe_n_o[0])
        else $error("backup resource pin driven");
    // main scenarios reached
    cover property (deep && pin_hold_select_i && f == LPPS_FUNC_WAKEUP);
    cover property (f == LPPS_FUNC_USB && !usb_transmit_i);
    cover property (sub_osc_stop_ctrl_i && mode_i == LPPS_MODE_DS_STOP);
    cover property (lowm && f == LPPS_FUNC_EXC2);
endmodule

// >>> tb_lpps_pin_ctrl.sv
// tb_lpps_pin_ctrl: swept and random pad state checks
// assumes lpps_pin_ctrl with four pins and its checker
`timescale 1ns/10ps
module tb_lpps_pin_ctrl;
    import lpps_pkg::*;
    logic clk_i = 1'h0, reset_i = 1'h1, pin_hold_select_i = 1'h0, sub_osc_stop_ctrl_i = 1'h0;
    logic backup_por_i = 1'h0, usb_transmit_i = 1'h0;
    lpps_mode_type mode_i = LPPS_MODE_RUN;
    lpps_func_type pin_func_i [4] = '{default: LPPS_FUNC_GPIO};
    logic [3:0] pad_oe_n_o, pad_in_en_o, pad_hold_o, pad_force_gpio_o, input_fixed_o;
    logic main_osc_run_o, main_osc_oe_n_o, sub_osc_run_o, sub_osc_hold_o, sub_osc_oe_n_o, lo, so;
    int failures = 0, checked = 0;
    lpps_pin_ctrl #(.PINS(4)) i_dut (.clk_i, .reset_i, .mode_i, .pin_hold_select_i, .sub_osc_stop_ctrl_i,
        .backup_por_i, .usb_transmit_i, .pin_func_i, .pad_oe_n_o, .pad_in_en_o, .pad_hold_o, .pad_force_gpio_o,
        .input_fixed_o, .main_osc_run_o, .main_osc_oe_n_o, .sub_osc_run_o, .sub_osc_hold_o, .sub_osc_oe_n_o);
    // clock
    always #25 clk_i = ~clk_i;
    // compare and count
    task automatic check(input logic [3:0] seen, input logic [3:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %0t %s", $time, what);
        end
    endtask
    task automatic conclude;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // expected {oe_n, in_en, hold, gpio, fixed} of one pin
    function automatic logic [4:0] exp_pad(lpps_mode_type m, lpps_func_type f);
        logic dp, rs, hd;
        dp = m inside {LPPS_MODE_DS_RTC, LPPS_MODE_DS_STOP};
        rs = m inside {LPPS_MODE_RTC, LPPS_MODE_STOP};
        hd = !(m inside {LPPS_MODE_RUN, LPPS_MODE_SLEEP});
        if ((backup_por_i && f == LPPS_FUNC_RESOURCE) || m <= LPPS_MODE_INT_RST) return 5'h18;
        if (f == LPPS_FUNC_USB) return {4'hc, ~usb_transmit_i};
        if (f == LPPS_FUNC_WAKEUP && dp && pin_hold_select_i) return 5'h18;
        if (f == LPPS_FUNC_EXC2 && rs) return 5'h03;
        if ((f == LPPS_FUNC_EXC3 && rs) || (f inside {LPPS_FUNC_GPIO, LPPS_FUNC_RESOURCE} && dp)) return 5'h11;
        if (f > LPPS_FUNC_RESOURCE) return {2'h2, hd, 2'h1};
        return {2'h1, hd, 2'h0};
    endfunction
    // check the state loaded at the next edge
    task automatic verify;
        logic [4:0] e;
        logic [3:0] st;
        @(posedge clk_i);
        #1;
        for (int i = 0; i < 4; i++) begin
            e = exp_pad(mode_i, pin_func_i[i]);
            st = {pad_in_en_o[i], pad_hold_o[i], pad_force_gpio_o[i], input_fixed_o[i]};
            check(4'(pad_oe_n_o[i]), 4'(e[4]), "pad enable");
            check(st, e[3:0], "pad state");
        end
        lo = mode_i inside {[LPPS_MODE_SUB_TIMER:LPPS_MODE_DS_STOP]};
        so = sub_osc_stop_ctrl_i && mode_i inside {LPPS_MODE_STOP, LPPS_MODE_DS_STOP};
        check({2'h0, main_osc_run_o, main_osc_oe_n_o}, {2'h0, ~lo, lo}, "main osc");
        check({1'h0, sub_osc_run_o, sub_osc_oe_n_o, sub_osc_hold_o}, {1'h0, ~so, so, ~so}, "sub osc");
    endtask
    // main sequence: reset, sweep of modes and functions, then random
    initial begin
        void'($urandom(32'hbc6b4120));
        repeat (10) @(posedge clk_i);
        check(pad_oe_n_o, 4'hf, "reset pads");
        reset_i <= 1'h0;
        for (int m = 0; m < 13; m++) begin
            for (int f = 0; f < 8; f++) begin
                @(posedge clk_i);
                mode_i <= lpps_mode_type'(m);
                pin_func_i <= '{default: lpps_func_type'(f)};
                pin_hold_select_i <= 1'h1;
                sub_osc_stop_ctrl_i <= m[0];
                usb_transmit_i <= m[1];
                backup_por_i <= f[0];
                verify();
            end
        end
        repeat (300) begin
            @(posedge clk_i);
            mode_i <= lpps_mode_type'($urandom_range(12));
            foreach (pin_func_i[i]) pin_func_i[i] <= lpps_func_type'($urandom_range(7));
            {pin_hold_select_i, sub_osc_stop_ctrl_i, backup_por_i, usb_transmit_i} <= 4'($urandom);
            verify();
        end
        conclude();
    end
    // watchdog
    initial begin
        #(2000 * 50);
        failures++;
        conclude();
    end
endmodule
bind lpps_pin_ctrl lpps_pin_ctrl_chk #(.PINS(PINS)) u_chk (.clk_i, .reset_i, .mode_i, .pin_hold_select_i,
    .sub_osc_stop_ctrl_i, .backup_por_i, .usb_transmit_i, .pin_func_i, .pad_oe_n_o, .pad_in_en_o, .pad_hold_o,
    .pad_force_gpio_o, .input_fixed_o, .main_osc_run_o, .main_osc_oe_n_o, .sub_osc_run_o, .sub_osc_hold_o,
    .sub_osc_oe_n_o);
